// ---- logic/fpc_cmd_if.sv ----
/*
 * Internal carrier from the command decoder to the partition selectors
 * and the status flags. Assumes a single clock shared by all users.
 */
`timescale 1ns/100ps
`default_nettype none
interface fpc_cmd_if #(parameter int PART_W = 3);
    logic sel_we;                  // Pulse: update one partition.
    logic [PART_W-1:0] sel_part;   // Partition of the update.
    fpc_pkg::fpc_sel_e sel_kind;   // New output kind.
    logic sel_we2;                 // Pulse: mismatched first partition to status.
    logic [PART_W-1:0] sel_part2;  // Partition of the first cycle.
    logic clr_err;                 // Pulse: clear the error flags.
    logic set_lock_err;            // Pulse: lock sequence error.
    logic set_pgm_err;             // Pulse: program error.
    logic set_ers_err;             // Pulse: erase error.
    modport ctrl (output sel_we, sel_part, sel_kind, sel_we2, sel_part2,
                  output clr_err, set_lock_err, set_pgm_err, set_ers_err);
    modport psel (input sel_we, sel_part, sel_kind, sel_we2, sel_part2);
    modport stat (input clr_err, set_lock_err, set_pgm_err, set_ers_err);
endinterface : fpc_cmd_if
`default_nettype wire

// ---- logic/fpc_part_sel.sv ----
/*
 * Per-partition output selection registers and the read-side mux.
 * Assumes the decoder raises at most one update per partition per cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module fpc_part_sel #(
    parameter int PART_W = 3
) (
    input wire logic clock,
    input wire logic reset_n,
    fpc_cmd_if.psel cmd,
    input wire logic [PART_W-1:0] rd_part,
    output fpc_pkg::fpc_sel_e rd_sel
);
    import fpc_pkg::*;

    localparam int NUM_PART = 2 ** PART_W;

    // Refuse partition counts that the one-hot decode cannot serve.
    if (PART_W < 1 || PART_W > 6) begin : g_chk
        $error("fpc_part_sel: PART_W out of range");
    end

    logic [NUM_PART-1:0][1:0] sel_vec; // Selections of all partitions.

    for (genvar p = 0; p < NUM_PART; p++) begin : g_part
        fpc_sel_e sel_q; // This partition's output kind.
        // A partition only moves when an update names it; others hold.
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                sel_q <= FPC_SEL_ARRAY;
            end else if (cmd.sel_we && cmd.sel_part == PART_W'(p)) begin
                sel_q <= cmd.sel_kind;
            end else if (cmd.sel_we2 && cmd.sel_part2 == PART_W'(p)) begin
                sel_q <= FPC_SEL_STATUS;
            end
        end
        assign sel_vec[p] = sel_q;
    end

    // Reads pick the selection of the addressed partition.
    assign rd_sel = fpc_sel_e'(sel_vec[rd_part]);
endmodule : fpc_part_sel
`default_nettype wire

// ---- logic/fpc_pkg.sv ----
/*
 * Shared constants and types of the partition command block.
 * Assumes nothing of its surroundings; the top, the partition selector, the checker and the bench import it.
 */
package fpc_pkg;
    // Command codes seen on the low byte of a write.
    localparam logic [7:0] FPC_OP_READ_ARRAY = 8'h0f;
    localparam logic [7:0] FPC_OP_READ_STATUS = 8'h07;
    localparam logic [7:0] FPC_OP_READ_IDENT = 8'h09;
    localparam logic [7:0] FPC_OP_READ_QUERY = 8'h08;
    localparam logic [7:0] FPC_OP_CLEAR_STATUS = 8'h05;
    localparam logic [7:0] FPC_OP_PROGRAM = 8'h04;
    localparam logic [7:0] FPC_OP_ERASE = 8'h02;
    localparam logic [7:0] FPC_OP_FACTORY = 8'h0e;
    localparam logic [7:0] FPC_OP_CONFIRM = 8'h0d;
    localparam logic [7:0] FPC_OP_SUSPEND = 8'h0b;
    localparam logic [7:0] FPC_OP_LOCK_SETUP = 8'h60;
    localparam logic [7:0] FPC_OP_OTP_SETUP = 8'hc0;
    localparam logic [7:0] FPC_OP_LOCK_BLOCK = 8'h01;
    localparam logic [7:0] FPC_OP_LOCK_DOWN = 8'h2f;
    localparam logic [7:0] FPC_OP_CFG_WRITE = 8'h03;
    // Status word bit positions.
    localparam int FPC_SR_READY = 7;
    localparam int FPC_SR_ERS_SUSP = 6;
    localparam int FPC_SR_ERS_ERR = 5;
    localparam int FPC_SR_PGM_ERR = 4;
    localparam int FPC_SR_PGM_SUSP = 2;
    localparam int FPC_SR_LOCK_ERR = 1;
    localparam int FPC_SR_BIT_ZERO = 0;
    // Kind of data a partition returns on reads.
    typedef enum logic [1:0] {
        FPC_SEL_ARRAY = 2'h0,
        FPC_SEL_STATUS = 2'h1,
        FPC_SEL_IDENT = 2'h2
    } fpc_sel_e;
    // Global write state machine states, one-hot.
    typedef enum logic [16:0] {
        FPC_ST_READY = 17'h00001,
        FPC_ST_LOCK_SETUP = 17'h00002,
        FPC_ST_OTP_SETUP = 17'h00004,
        FPC_ST_OTP_BUSY = 17'h00008,
        FPC_ST_PGM_SETUP = 17'h00010,
        FPC_ST_PGM_BUSY = 17'h00020,
        FPC_ST_PGM_SUSP = 17'h00040,
        FPC_ST_ERS_SETUP = 17'h00080,
        FPC_ST_ERS_BUSY = 17'h00100,
        FPC_ST_ERS_SUSP = 17'h00200,
        FPC_ST_PES_SETUP = 17'h00400,
        FPC_ST_PES_BUSY = 17'h00800,
        FPC_ST_PES_SUSP = 17'h01000,
        FPC_ST_LOCK_ES = 17'h02000,
        FPC_ST_EFP_SETUP = 17'h04000,
        FPC_ST_EFP_BUSY = 17'h08000,
        FPC_ST_EFP_VERIFY = 17'h10000
    } fpc_state_e;
endpackage : fpc_pkg

// ---- logic/fpc_status.sv ----
/*
 * Sticky error flags of the status word.
 * Assumes clear and set pulses come from the decoder on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module fpc_status (
    input wire logic clock,
    input wire logic reset_n,
    fpc_cmd_if.stat cmd,
    output logic [2:0] err_bits
);
    logic lock_err_q; // Lock or configuration sequence error.
    logic pgm_err_q;  // Program error.
    logic ers_err_q;  // Erase error.

    // A set in the clearing cycle wins so no error is lost.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lock_err_q <= 1'b0;
            pgm_err_q <= 1'b0;
            ers_err_q <= 1'b0;
        end else begin
            lock_err_q <= cmd.set_lock_err | (lock_err_q & ~cmd.clr_err);
            pgm_err_q <= cmd.set_pgm_err | (pgm_err_q & ~cmd.clr_err);
            ers_err_q <= cmd.set_ers_err | (ers_err_q & ~cmd.clr_err);
        end
    end

    assign err_bits = {ers_err_q, pgm_err_q, lock_err_q};
endmodule : fpc_status
`default_nettype wire

// ---- logic/fpc_top.sv ----
/*
 * Command interpreter of a multi-partition flash: the global write state
 * machine, per-partition output kind and the status word.
 * Assumes the host writes on the same clock, one write per wr_valid pulse,
 * and an array engine that reports completion through op_done.
 */
`timescale 1ns/100ps
`default_nettype none
module fpc_top #(
    parameter int PART_W = 3,
    parameter int BLK_W = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wr_valid,
    input wire logic [PART_W-1:0] wr_part,
    input wire logic [BLK_W-1:0] wr_block,
    input wire logic [15:0] wr_data,
    input wire logic [PART_W-1:0] rd_part,
    input wire logic op_done,
    input wire logic op_fail,
    input wire logic efp_word_busy,
    output fpc_pkg::fpc_state_e wsm_state,
    output fpc_pkg::fpc_sel_e rd_sel,
    output logic rd_undefined,
    output logic [7:0] status_word,
    output logic op_start,
    output logic [BLK_W-1:0] op_block,
    output logic [15:0] op_data,
    output logic efp_data_valid,
    output logic lock_op,
    output logic [7:0] lock_code,
    output logic suspend_req,
    output logic resume_req
);
    import fpc_pkg::*;

    // Refuse widths the address fields cannot hold.
    if (PART_W < 1 || PART_W > 6 || BLK_W < 1) begin : g_chk
        $error("fpc_top: PART_W or BLK_W out of range");
    end

    fpc_cmd_if #(.PART_W(PART_W)) cmd ();

    fpc_state_e state_q;            // Global machine state.
    fpc_state_e state_d;            // Its next value.
    logic [PART_W-1:0] first_part_q; // Partition of a setup cycle.
    logic [PART_W-1:0] busy_part_q;  // Partition owning the running job.
    logic [BLK_W-1:0] efp_block_q;   // Block latched at factory confirm.
    logic [7:0] status_q;            // Registered status word.
    logic [2:0] err_bits;            // Sticky errors from the flag module.
    logic [7:0] op;                  // Command byte of the current write.
    logic running;                   // Machine is executing a job.
    logic in_setup;                  // Current write is a second cycle.
    logic start_d;                   // Launch an array job.
    logic lock_d;                    // Carry out a lock or config write.
    logic efp_word_d;                // Pass one factory data word.
    logic susp_d;                    // Ask the engine to suspend.
    logic resume_d;                  // Ask the engine to resume.
    logic lock_err_d;                // Flag a lock sequence error.
    logic pgm_err_d;                 // Flag a program error.
    logic ers_err_d;                 // Flag an erase error.

    assign op = wr_data[7:0];

    // Job states in which the engine owns the array.
    assign running = state_q inside {FPC_ST_OTP_BUSY, FPC_ST_PGM_BUSY, FPC_ST_ERS_BUSY,
                                     FPC_ST_PES_BUSY, FPC_ST_EFP_BUSY, FPC_ST_EFP_VERIFY};

    // States whose next write is the second cycle of a command.
    assign in_setup = state_q inside {FPC_ST_LOCK_SETUP, FPC_ST_OTP_SETUP, FPC_ST_PGM_SETUP,
                                      FPC_ST_ERS_SETUP, FPC_ST_PES_SETUP, FPC_ST_LOCK_ES,
                                      FPC_ST_EFP_SETUP};

    // Next-state logic. It reads only the machine state, the write and the
    // engine, never the partition selections, so reads cannot perturb it.
    always_comb begin
        state_d = state_q;
        start_d = 1'b0;
        lock_d = 1'b0;
        efp_word_d = 1'b0;
        susp_d = 1'b0;
        resume_d = 1'b0;
        lock_err_d = 1'b0;
        pgm_err_d = 1'b0;
        ers_err_d = 1'b0;
        if (op_done && running) begin
            // Completion beats any write landing in the same cycle.
            case (state_q)
                FPC_ST_ERS_BUSY: begin
                    state_d = FPC_ST_READY;
                    ers_err_d = op_fail;
                end
                FPC_ST_PES_BUSY: begin
                    state_d = FPC_ST_ERS_SUSP;
                    pgm_err_d = op_fail;
                end
                FPC_ST_EFP_BUSY: begin
                    state_d = FPC_ST_EFP_BUSY;
                end
                default: begin
                    state_d = FPC_ST_READY;
                    pgm_err_d = op_fail;
                end
            endcase
        end else if (wr_valid) begin
            case (state_q)
                FPC_ST_READY: begin
                    // Single-cycle reads stay; unknown codes fall through.
                    case (op)
                        FPC_OP_LOCK_SETUP: state_d = FPC_ST_LOCK_SETUP;
                        FPC_OP_OTP_SETUP: state_d = FPC_ST_OTP_SETUP;
                        FPC_OP_PROGRAM: state_d = FPC_ST_PGM_SETUP;
                        FPC_OP_ERASE: state_d = FPC_ST_ERS_SETUP;
                        FPC_OP_FACTORY: state_d = FPC_ST_EFP_SETUP;
                        default: state_d = FPC_ST_READY;
                    endcase
                end
                FPC_ST_LOCK_SETUP: begin
                    state_d = FPC_ST_READY;
                    if (op inside {FPC_OP_LOCK_BLOCK, FPC_OP_CONFIRM,
                                   FPC_OP_LOCK_DOWN, FPC_OP_CFG_WRITE}) begin
                        lock_d = 1'b1;
                    end else begin
                        lock_err_d = 1'b1;
                    end
                end
                FPC_ST_LOCK_ES: begin
                    state_d = FPC_ST_ERS_SUSP;
                    if (op inside {FPC_OP_LOCK_BLOCK, FPC_OP_CONFIRM,
                                   FPC_OP_LOCK_DOWN, FPC_OP_CFG_WRITE}) begin
                        lock_d = 1'b1;
                    end else begin
                        lock_err_d = 1'b1;
                    end
                end
                FPC_ST_OTP_SETUP: begin
                    state_d = FPC_ST_OTP_BUSY;
                    start_d = 1'b1;
                end
                FPC_ST_PGM_SETUP: begin
                    state_d = FPC_ST_PGM_BUSY;
                    start_d = 1'b1;
                end
                FPC_ST_PES_SETUP: begin
                    state_d = FPC_ST_PES_BUSY;
                    start_d = 1'b1;
                end
                FPC_ST_ERS_SETUP: begin
                    // Anything but a confirm aborts with both errors.
                    if (op == FPC_OP_CONFIRM) begin
                        state_d = FPC_ST_ERS_BUSY;
                        start_d = 1'b1;
                    end else begin
                        state_d = FPC_ST_READY;
                        ers_err_d = 1'b1;
                        pgm_err_d = 1'b1;
                    end
                end
                FPC_ST_EFP_SETUP: begin
                    if (op == FPC_OP_CONFIRM) begin
                        state_d = FPC_ST_EFP_BUSY;
                        start_d = 1'b1;
                    end else begin
                        state_d = FPC_ST_READY;
                        pgm_err_d = 1'b1;
                    end
                end
                FPC_ST_EFP_BUSY: begin
                    // Writes to the latched block are data, even command-like values; another block ends the phase.
                    if (wr_block != efp_block_q) begin
                        state_d = FPC_ST_EFP_VERIFY;
                    end else if (!status_q[FPC_SR_BIT_ZERO]) begin
                        efp_word_d = 1'b1;
                    end
                end
                FPC_ST_PGM_BUSY, FPC_ST_ERS_BUSY, FPC_ST_PES_BUSY: begin
                    // Only suspend is heard; two-cycle commands drop.
                    if (op == FPC_OP_SUSPEND) begin
                        susp_d = 1'b1;
                        case (state_q)
                            FPC_ST_PGM_BUSY: state_d = FPC_ST_PGM_SUSP;
                            FPC_ST_ERS_BUSY: state_d = FPC_ST_ERS_SUSP;
                            default: state_d = FPC_ST_PES_SUSP;
                        endcase
                    end else begin
                        state_d = state_q;
                    end
                end
                FPC_ST_PGM_SUSP, FPC_ST_PES_SUSP: begin
                    if (op == FPC_OP_CONFIRM) begin
                        resume_d = 1'b1;
                        state_d = (state_q == FPC_ST_PGM_SUSP) ? FPC_ST_PGM_BUSY
                                                               : FPC_ST_PES_BUSY;
                    end else begin
                        state_d = state_q;
                    end
                end
                FPC_ST_ERS_SUSP: begin
                    case (op)
                        FPC_OP_CONFIRM: begin
                            resume_d = 1'b1;
                            state_d = FPC_ST_ERS_BUSY;
                        end
                        FPC_OP_PROGRAM: state_d = FPC_ST_PES_SETUP;
                        FPC_OP_LOCK_SETUP: state_d = FPC_ST_LOCK_ES;
                        default: state_d = FPC_ST_ERS_SUSP;
                    endcase
                end
                default: state_d = state_q;
            endcase
        end
    end

    // Output-kind updates; a split pair shows status on both partitions.
    always_comb begin
        cmd.sel_we = 1'b0;
        cmd.sel_part = wr_part;
        cmd.sel_kind = FPC_SEL_STATUS;
        cmd.sel_we2 = 1'b0;
        cmd.sel_part2 = first_part_q;
        if (wr_valid && !(op_done && running)) begin
            if (in_setup) begin
                cmd.sel_we = 1'b1;
                cmd.sel_we2 = (first_part_q != wr_part);
            end else if (state_q inside {FPC_ST_EFP_BUSY, FPC_ST_EFP_VERIFY}) begin
                cmd.sel_we = 1'b1;
            end else begin
                case (op)
                    FPC_OP_READ_ARRAY: begin
                        cmd.sel_we = 1'b1;
                        cmd.sel_kind = FPC_SEL_ARRAY;
                    end
                    FPC_OP_READ_STATUS: cmd.sel_we = 1'b1;
                    FPC_OP_READ_IDENT, FPC_OP_READ_QUERY: begin
                        cmd.sel_we = 1'b1;
                        cmd.sel_kind = FPC_SEL_IDENT;
                    end
                    default: cmd.sel_we = (state_d != state_q) && !resume_d && !susp_d;
                endcase
            end
        end
    end

    // Error flags: clearing is honoured only with the machine idle.
    assign cmd.clr_err = wr_valid && op == FPC_OP_CLEAR_STATUS && state_q == FPC_ST_READY;
    assign cmd.set_lock_err = lock_err_d;
    assign cmd.set_pgm_err = pgm_err_d;
    assign cmd.set_ers_err = ers_err_d;

    // Machine state register.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= FPC_ST_READY;
        end else begin
            state_q <= state_d;
        end
    end

    // Partition of each first cycle, compared on the second.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            first_part_q <= '0;
        end else if (wr_valid && !in_setup) begin
            first_part_q <= wr_part;
        end
    end

    // The second write names the active partition and block of a job.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_part_q <= '0;
            efp_block_q <= '0;
        end else if (start_d) begin
            busy_part_q <= wr_part;
            efp_block_q <= wr_block;
        end
    end

    // Pulses and data toward the array engine, all from flops.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            op_start <= 1'b0;
            efp_data_valid <= 1'b0;
            lock_op <= 1'b0;
            suspend_req <= 1'b0;
            resume_req <= 1'b0;
            op_block <= '0;
            op_data <= 16'h0000;
            lock_code <= 8'h00;
        end else begin
            op_start <= start_d;
            efp_data_valid <= efp_word_d;
            lock_op <= lock_d;
            suspend_req <= susp_d;
            resume_req <= resume_d;
            if (start_d || efp_word_d || lock_d) begin
                op_block <= wr_block;
                op_data <= wr_data;
            end
            if (lock_d) begin
                lock_code <= op;
            end
        end
    end

    // Status word; bit zero mirrors the engine's factory word handshake.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= 8'h80;
        end else begin
            status_q <= '0;
            status_q[FPC_SR_READY] <= ~running;
            status_q[FPC_SR_ERS_SUSP] <= state_q inside {FPC_ST_ERS_SUSP, FPC_ST_PES_SETUP,
                                                         FPC_ST_PES_BUSY, FPC_ST_PES_SUSP,
                                                         FPC_ST_LOCK_ES};
            status_q[FPC_SR_ERS_ERR] <= err_bits[2];
            status_q[FPC_SR_PGM_ERR] <= err_bits[1];
            status_q[FPC_SR_PGM_SUSP] <= state_q inside {FPC_ST_PGM_SUSP, FPC_ST_PES_SUSP};
            status_q[FPC_SR_LOCK_ERR] <= err_bits[0];
            status_q[FPC_SR_BIT_ZERO] <= efp_word_busy;
        end
    end

    fpc_part_sel #(.PART_W(PART_W)) u_part_sel (
        .clock(clock),
        .reset_n(reset_n),
        .cmd(cmd.psel),
        .rd_part(rd_part),
        .rd_sel(rd_sel)
    );

    fpc_status u_status (
        .clock(clock),
        .reset_n(reset_n),
        .cmd(cmd.stat),
        .err_bits(err_bits)
    );

    // Array reads of the partition the engine is working on are not valid.
    assign rd_undefined = running && rd_part == busy_part_q && rd_sel == FPC_SEL_ARRAY;

    assign wsm_state = state_q;
    assign status_word = status_q;
endmodule : fpc_top
`default_nettype wire

// ---- testbench/fpc_host_model.sv ----
/* Host controller model issuing single write cycles.
   Assumes the block samples writes on the rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module fpc_host_model (
    input wire logic clock,
    output logic wr_valid,
    output logic [2:0] wr_part,
    output logic [7:0] wr_block,
    output logic [15:0] wr_data
);
    // One write pulse; idle data is inverted.
    task automatic wr(input logic [2:0] p, input logic [7:0] b, input logic [15:0] d);
        @(negedge clock);
        wr_valid = 1'b1;
        wr_part = p;
        wr_block = b;
        wr_data = d;
        @(negedge clock);
        wr_valid = 1'b0;
        wr_data = ~d;
    endtask : wr
    initial wr_valid = 1'b0;
endmodule : fpc_host_model
`default_nettype wire

// ---- testbench/fpc_top_sva.sv ----
/* Assertions on the ports of the command block.
   Assumes one clock and the active-low asynchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module fpc_top_sva #(
    parameter int BLK_W = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wr_valid,
    input wire logic [BLK_W-1:0] wr_block,
    input wire logic [15:0] wr_data,
    input wire logic op_done,
    input wire fpc_pkg::fpc_state_e wsm_state,
    input wire fpc_pkg::fpc_sel_e rd_sel,
    input wire logic [7:0] status_word,
    input wire logic [BLK_W-1:0] op_block,
    input wire logic lock_op,
    input wire logic [7:0] lock_code,
    input wire logic efp_data_valid
);
    import fpc_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_reset_array: assert property ($rose(reset_n) |-> rd_sel == FPC_SEL_ARRAY) else $error("not array after reset");
    a_busy_ignores: assert property (wr_valid && !op_done && wsm_state == FPC_ST_PGM_BUSY && wr_data[7:0] != FPC_OP_SUSPEND
        |=> wsm_state == FPC_ST_PGM_BUSY) else $error("busy machine moved");
    a_clear_blocked: assert property (wr_valid && wsm_state == FPC_ST_ERS_SUSP && wr_data[7:0] == FPC_OP_CLEAR_STATUS
        |=> (!$fell(status_word[5]) && !$fell(status_word[1]))[*2]) else $error("clear acted in suspend");
    a_lock_confirm: assert property (wr_valid && wsm_state == FPC_ST_LOCK_SETUP && wr_data[7:0] == FPC_OP_LOCK_DOWN
        |=> lock_op && lock_code == FPC_OP_LOCK_DOWN && wsm_state == FPC_ST_READY) else $error("lock confirm");
    a_erase_susp_only: assert property (wr_valid && wsm_state == FPC_ST_ERS_SUSP && !(wr_data[7:0] inside {8'h0d, 8'h04, 8'h60})
        |=> wsm_state == FPC_ST_ERS_SUSP) else $error("erase suspend left");
    a_pgm_susp_hold: assert property (wr_valid && wsm_state == FPC_ST_PGM_SUSP && wr_data[7:0] != FPC_OP_CONFIRM
        |=> wsm_state == FPC_ST_PGM_SUSP) else $error("program suspend left");
    a_lock_susp_err: assert property (wr_valid && wsm_state == FPC_ST_LOCK_ES && !(wr_data[7:0] inside {8'h01, 8'h0d, 8'h2f, 8'h03})
        |=> wsm_state == FPC_ST_ERS_SUSP ##1 status_word[FPC_SR_LOCK_ERR]) else $error("lock error missing");
    a_efp_word: assert property (wr_valid && !op_done && wsm_state == FPC_ST_EFP_BUSY && wr_block == op_block && !status_word[0]
        |=> efp_data_valid) else $error("factory word lost");
endmodule : fpc_top_sva
bind fpc_top fpc_top_sva #(.BLK_W(BLK_W)) u_sva (.clock(clock), .reset_n(reset_n), .wr_valid(wr_valid),
    .wr_block(wr_block), .wr_data(wr_data), .op_done(op_done), .wsm_state(wsm_state), .rd_sel(rd_sel),
    .status_word(status_word), .op_block(op_block), .lock_op(lock_op), .lock_code(lock_code),
    .efp_data_valid(efp_data_valid));
`default_nettype wire

// ---- testbench/tb_fpc_top.sv ----
/* Self-checking bench of the command block.
   Assumes the host model and the checker bound to the top. */
`timescale 1ns/100ps
`default_nettype none
module tb_fpc_top;
    import fpc_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, op_done = 1'b0, efp_word_busy = 1'b0, wr_valid, rd_undefined, efp_data_valid;
    logic [2:0] rd_part = 3'h0, wr_part;
    logic [7:0] wr_block, status_word, op_block, lock_code;
    logic [15:0] wr_data, op_data;
    fpc_state_e wsm_state;
    fpc_sel_e rd_sel;
    int err_total = 0, total_checks = 0;
    always #4 clock = ~clock;
    fpc_host_model host (.clock(clock), .wr_valid(wr_valid), .wr_part(wr_part), .wr_block(wr_block), .wr_data(wr_data));
    fpc_top dut (.clock(clock), .reset_n(reset_n), .wr_valid(wr_valid), .wr_part(wr_part), .wr_block(wr_block),
        .wr_data(wr_data), .rd_part(rd_part), .op_done(op_done), .op_fail(1'b0), .efp_word_busy(efp_word_busy),
        .wsm_state(wsm_state), .rd_sel(rd_sel), .rd_undefined(rd_undefined), .status_word(status_word),
        .op_start(), .op_block(op_block), .op_data(op_data), .efp_data_valid(efp_data_valid), .lock_op(),
        .lock_code(lock_code), .suspend_req(), .resume_req());
    // Counts every comparison and reports each mismatch.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rs(input logic [2:0] p, input logic [1:0] e);
        rd_part = p;
        #1 chk("rd_sel", {30'h0, e}, {30'h0, rd_sel});
    endtask : rs
    task automatic done();
        @(negedge clock) op_done = 1'b1;
        @(negedge clock) op_done = 1'b0;
    endtask : done
    task automatic t_modes();
        logic [7:0] code [4] = '{8'h0f, 8'h07, 8'h09, 8'h08};
        logic [1:0] kind [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
        for (int p = 0; p < 8; p++) rs(p[2:0], FPC_SEL_ARRAY);
        chk("status", 8'h80, status_word);
        for (int i = 3; i >= 0; i--) begin
            host.wr(3'h2, 8'h00, {8'h00, code[i]});
            rs(3'h2, kind[i]);
            rs(3'h3, FPC_SEL_ARRAY);
        end
        $display("modes test done");
    endtask : t_modes
    task automatic t_prog();
        host.wr(3'h5, 8'h00, 16'h0004);
        host.wr(3'h6, 8'h10, 16'h1234);
        rs(3'h5, FPC_SEL_STATUS);
        host.wr(3'h6, 8'h00, 16'h0004);
        chk("state", FPC_ST_PGM_BUSY, wsm_state);
        host.wr(3'h6, 8'h00, 16'h000f);
        rs(3'h6, FPC_SEL_ARRAY);
        chk("undefined", 1'b1, rd_undefined);
        host.wr(3'h6, 8'h00, 16'h000b);
        host.wr(3'h6, 8'h00, 16'h0060);
        chk("state", FPC_ST_PGM_SUSP, wsm_state);
        host.wr(3'h6, 8'h00, 16'h000d);
        done();
        chk("state", FPC_ST_READY, wsm_state);
        $display("program test done");
    endtask : t_prog
    task automatic t_lock();
        host.wr(3'h0, 8'h00, 16'h0060);
        host.wr(3'h0, 8'h00, 16'h002f);
        chk("lock code", 8'h2f, lock_code);
        host.wr(3'h0, 8'h00, 16'h0060);
        host.wr(3'h0, 8'h00, 16'h00aa);
        @(negedge clock) chk("lock err", 1'b1, status_word[1]);
        host.wr(3'h0, 8'h00, 16'h0005);
        @(negedge clock) chk("lock err", 1'b0, status_word[1]);
        $display("lock test done");
    endtask : t_lock
    task automatic t_erase();
        host.wr(3'h0, 8'h03, 16'h0002);
        host.wr(3'h0, 8'h03, 16'h000d);
        host.wr(3'h0, 8'h03, 16'h000b);
        host.wr(3'h0, 8'h03, 16'h0002);
        chk("state", FPC_ST_ERS_SUSP, wsm_state);
        host.wr(3'h0, 8'h03, 16'h0060);
        host.wr(3'h0, 8'h03, 16'h0099);
        host.wr(3'h0, 8'h03, 16'h0005);
        @(negedge clock) chk("lock err", 1'b1, status_word[1]);
        host.wr(3'h0, 8'h03, 16'h000d);
        done();
        $display("erase test done");
    endtask : t_erase
    task automatic t_efp();
        host.wr(3'h1, 8'h05, 16'h000e);
        host.wr(3'h1, 8'h05, 16'h000d);
        efp_word_busy = 1'b1;
        repeat (2) @(negedge clock);
        host.wr(3'h1, 8'h05, 16'h0002);
        chk("word taken", 1'b0, efp_data_valid);
        efp_word_busy = 1'b0;
        repeat (2) @(negedge clock);
        host.wr(3'h1, 8'h05, 16'h0005);
        chk("word data", 16'h0005, op_data);
        host.wr(3'h1, 8'h06, 16'h0000);
        chk("state", FPC_ST_EFP_VERIFY, wsm_state);
        done();
        chk("state", FPC_ST_READY, wsm_state);
        $display("factory test done");
    endtask : t_efp
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (16) @(negedge clock);
        reset_n = 1'b1;
        t_modes();
        t_prog();
        t_lock();
        t_erase();
        t_efp();
        conclude();
    end
    // Hang guard; the run needs under a hundred cycles.
    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        conclude();
    end
endmodule : tb_fpc_top
`default_nettype wire
